// ### include/mie_defs.vh
// constants for the instruction execute subset
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH
// operation codes presented on op
`define MIE_OP_IDLE 5'h00
`define MIE_OP_DEC_M 5'h01
`define MIE_OP_DEC_A 5'h02
`define MIE_OP_INC_M 5'h03
`define MIE_OP_INC_A 5'h04
`define MIE_OP_HALT 5'h05
`define MIE_OP_JMP 5'h06
`define MIE_OP_MOV_MA 5'h07
`define MIE_OP_MOV_XA 5'h08
`define MIE_OP_MOV_AM 5'h09
`define MIE_OP_OR_A 5'h0A
`define MIE_OP_OR_X 5'h0B
`define MIE_OP_OR_M 5'h0C
`define MIE_OP_RET 5'h0D
`define MIE_OP_RET_X 5'h0E
`define MIE_OP_LEAVE_INTERRUPT_HANDLER 5'h0F
`define MIE_OP_RL_M 5'h10
`define MIE_OP_RL_A 5'h11
`define MIE_OP_RLC_M 5'h12
`define MIE_OP_RLC_A 5'h13
`define MIE_OP_RR_M 5'h14
`define MIE_OP_RR_A 5'h15
`define MIE_OP_RRC_M 5'h16
`define MIE_OP_RRC_A 5'h17
`define MIE_OP_SBC_A 5'h18
`define MIE_OP_SBC_M 5'h19
`define MIE_OP_SDZ_M 5'h1A
`define MIE_OP_SDZ_A 5'h1B
// status flag bit positions
`define MIE_FLAG_C 0
`define MIE_FLAG_AC 1
`define MIE_FLAG_Z 2
`define MIE_FLAG_OV 3
`define MIE_FLAG_PDF 4
`define MIE_FLAG_TO 5
`define MIE_STATUS_RESET 6'h00
`define MIE_ACC_RESET 8'h00
`endif

// ### hw/mie_execute.v
// execute stage for a subset of the 8-bit core instruction set
`timescale 1ns/1ps
`default_nettype none
`include "mie_defs.vh"
module mie_execute #(
  parameter PC_W = 14
) (
  input wire clock,
  input wire resetn,
  input wire op_valid,
  input wire [4:0] op,
  input wire [7:0] operand,
  input wire [PC_W-1:0] branch_addr,
  input wire [7:0] mem_rdata,
  input wire [PC_W-1:0] stack_top,
  input wire irq_pending,
  output reg op_ready,
  output reg mem_we,
  output reg [7:0] mem_wdata,
  output reg [7:0] acc,
  output reg [5:0] status,
  output reg master_irq_enable,
  output reg pc_load,
  output reg [PC_W-1:0] pc_value,
  output reg stack_pop,
  output reg skip_next,
  output reg halted,
  output reg watchdog_clear,
  output reg irq_service
);

//////////////////////////////////////////////////////////////////////////////
localparam ST_RUN = 2'b01;
localparam ST_DUMMY = 2'b10;

// every result shows one cycle after the edge that takes the op
// pulses (write, load, pop, skip, clear) last exactly that one cycle
// a two-cycle op parks in the dummy state for one edge; op_valid is
// ignored there, so the fetch side may leave the next op waiting
// halt freezes the block until reset: there is no wake-up path here,
// the power manager owns that and restarts us through resetn
// carry into rotates and borrow into subtract is the flag before the op

// sequencing
reg [1:0] state;

// next values of the registered outputs
reg [7:0] next_acc;
reg [7:0] next_wdata;
reg next_we;
reg [5:0] next_status;
reg next_mie;
reg next_pc_load;
reg [PC_W-1:0] next_pc;
reg next_pop;
reg next_skip;
reg next_halt;
reg next_wdclr;
reg next_two;
reg next_irq_service;

// arithmetic scratch for subtract with borrow
reg [8:0] diff;
reg [4:0] half;
reg borrow_in;
wire cflag = status[`MIE_FLAG_C];
wire [7:0] m_dec = mem_rdata - 8'h01;
wire [7:0] m_inc = mem_rdata + 8'h01;
wire [7:0] ored = acc | mem_rdata;
wire [7:0] ored_x = acc | operand;
wire take = op_valid && state == ST_RUN && !halted;

//////////////////////////////////////////////////////////////////////////////
always @* begin
  next_acc = acc;
  next_wdata = mem_wdata;
  next_we = 1'b0;
  next_status = status;
  next_mie = master_irq_enable;
  next_pc_load = 1'b0;
  next_pc = pc_value;
  next_pop = 1'b0;
  next_skip = 1'b0;
  next_halt = halted;
  next_wdclr = 1'b0;
  next_two = 1'b0;
  next_irq_service = 1'b0;
  // borrow means an inverted carry enters the subtraction
  borrow_in = ~cflag;
  diff = {1'b0, acc} - {1'b0, mem_rdata} - {8'h00, borrow_in};
  half = {1'b0, acc[3:0]} - {1'b0, mem_rdata[3:0]} - {4'h0, borrow_in};
  if (take) begin
    case (op)

      // decrement and increment
      `MIE_OP_DEC_M: begin
        next_we = 1'b1;
        next_wdata = m_dec;
        next_status[`MIE_FLAG_Z] = (m_dec == 8'h00);
      end
      `MIE_OP_DEC_A: begin
        next_acc = m_dec;
        next_status[`MIE_FLAG_Z] = (m_dec == 8'h00);
      end
      `MIE_OP_INC_M: begin
        next_we = 1'b1;
        next_wdata = m_inc;
        next_status[`MIE_FLAG_Z] = (m_inc == 8'h00);
      end
      `MIE_OP_INC_A: begin
        next_acc = m_inc;
        next_status[`MIE_FLAG_Z] = (m_inc == 8'h00);
      end

      // power-down and branch
      `MIE_OP_HALT: begin
        next_halt = 1'b1;
        next_wdclr = 1'b1;
        next_status[`MIE_FLAG_PDF] = 1'b1;
        next_status[`MIE_FLAG_TO] = 1'b0;
      end
      `MIE_OP_JMP: begin
        next_pc_load = 1'b1;
        next_pc = branch_addr;
        next_two = 1'b1;
      end

      // moves leave every flag alone
      `MIE_OP_MOV_MA: next_acc = mem_rdata;
      `MIE_OP_MOV_XA: next_acc = operand;
      `MIE_OP_MOV_AM: begin
        next_we = 1'b1;
        next_wdata = acc;
      end

      // inclusive or
      `MIE_OP_OR_A: begin
        next_acc = ored;
        next_status[`MIE_FLAG_Z] = (ored == 8'h00);
      end
      `MIE_OP_OR_X: begin
        next_acc = ored_x;
        next_status[`MIE_FLAG_Z] = (ored_x == 8'h00);
      end
      `MIE_OP_OR_M: begin
        next_we = 1'b1;
        next_wdata = ored;
        next_status[`MIE_FLAG_Z] = (ored == 8'h00);
      end

      // returns reload the counter, so they cost two cycles
      `MIE_OP_RET, `MIE_OP_RET_X, `MIE_OP_LEAVE_INTERRUPT_HANDLER: begin
        next_pop = 1'b1;
        next_pc_load = 1'b1;
        next_pc = stack_top;
        next_two = 1'b1;
        if (op == `MIE_OP_RET_X)
          next_acc = operand;
        if (op == `MIE_OP_LEAVE_INTERRUPT_HANDLER) begin
          next_mie = 1'b1;
          // a waiting request is vectored before the main program resumes
          next_irq_service = irq_pending;
        end
      end

      // rotates
      `MIE_OP_RL_M: begin
        next_we = 1'b1;
        next_wdata = {mem_rdata[6:0], mem_rdata[7]};
      end
      `MIE_OP_RL_A: next_acc = {mem_rdata[6:0], mem_rdata[7]};
      `MIE_OP_RLC_M: begin
        next_we = 1'b1;
        next_wdata = {mem_rdata[6:0], cflag};
        next_status[`MIE_FLAG_C] = mem_rdata[7];
      end
      `MIE_OP_RLC_A: begin
        next_acc = {mem_rdata[6:0], cflag};
        next_status[`MIE_FLAG_C] = mem_rdata[7];
      end
      `MIE_OP_RR_M: begin
        next_we = 1'b1;
        next_wdata = {mem_rdata[0], mem_rdata[7:1]};
      end
      `MIE_OP_RR_A: next_acc = {mem_rdata[0], mem_rdata[7:1]};
      `MIE_OP_RRC_M: begin
        next_we = 1'b1;
        next_wdata = {cflag, mem_rdata[7:1]};
        next_status[`MIE_FLAG_C] = mem_rdata[0];
      end
      `MIE_OP_RRC_A: begin
        next_acc = {cflag, mem_rdata[7:1]};
        next_status[`MIE_FLAG_C] = mem_rdata[0];
      end

      // subtract with borrow
      `MIE_OP_SBC_A, `MIE_OP_SBC_M: begin
        if (op == `MIE_OP_SBC_M) begin
          next_we = 1'b1;
          next_wdata = diff[7:0];
        end else begin
          next_acc = diff[7:0];
        end
        next_status[`MIE_FLAG_Z] = (diff[7:0] == 8'h00);
        next_status[`MIE_FLAG_C] = ~diff[8];
        next_status[`MIE_FLAG_AC] = ~half[4];
        next_status[`MIE_FLAG_OV] = (acc[7] != mem_rdata[7]) &&
                                    (diff[7] != acc[7]);
      end

      // decrement and skip: only a taken skip costs the dummy slot
      `MIE_OP_SDZ_M: begin
        next_we = 1'b1;
        next_wdata = m_dec;
        next_skip = (m_dec == 8'h00);
        next_two = (m_dec == 8'h00);
      end
      `MIE_OP_SDZ_A: begin
        next_acc = m_dec;
        next_skip = (m_dec == 8'h00);
        next_two = (m_dec == 8'h00);
      end
      default: begin
      end
    endcase
  end
end

//////////////////////////////////////////////////////////////////////////////
// halt is left only by reset here; wake-up belongs to the power manager
always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    state <= ST_RUN;
    op_ready <= 1'b0;
    mem_we <= 1'b0;
    mem_wdata <= 8'h00;
    acc <= `MIE_ACC_RESET;
    status <= `MIE_STATUS_RESET;
    master_irq_enable <= 1'b0;
    pc_load <= 1'b0;
    pc_value <= {PC_W{1'b0}};
    stack_pop <= 1'b0;
    skip_next <= 1'b0;
    halted <= 1'b0;
    watchdog_clear <= 1'b0;
    irq_service <= 1'b0;
  end else begin
    acc <= next_acc;
    mem_we <= next_we;
    mem_wdata <= next_wdata;
    status <= next_status;
    master_irq_enable <= next_mie;
    pc_load <= next_pc_load;
    pc_value <= next_pc;
    stack_pop <= next_pop;
    skip_next <= next_skip;
    halted <= next_halt;
    watchdog_clear <= next_wdclr;
    irq_service <= next_irq_service;
    case (state)
      ST_RUN: begin
        if (next_two || next_halt) begin
          state <= next_two ? ST_DUMMY : ST_RUN;
          op_ready <= 1'b0;
        end else begin
          op_ready <= 1'b1;
        end
      end
      ST_DUMMY: begin
        state <= ST_RUN;
        op_ready <= 1'b1;
      end
      default: begin
        state <= ST_RUN;
        op_ready <= 1'b0;
      end
    endcase
  end
end

endmodule
`default_nettype wire

// ### verification/mie_execute_properties.sv
// concurrent checks on the execute subset ports
`timescale 1ns/1ps
`default_nettype none
`include "mie_defs.vh"
module mie_execute_properties #(parameter PC_W = 14) (
  input wire clock,
  input wire resetn,
  input wire op_valid,
  input wire [4:0] op,
  input wire [7:0] mem_rdata,
  input wire [PC_W-1:0] branch_addr,
  input wire [PC_W-1:0] stack_top,
  input wire irq_pending,
  input wire op_ready,
  input wire mem_we,
  input wire [7:0] mem_wdata,
  input wire [7:0] acc,
  input wire [5:0] status,
  input wire master_irq_enable,
  input wire pc_load,
  input wire [PC_W-1:0] pc_value,
  input wire stack_pop,
  input wire skip_next,
  input wire halted,
  input wire watchdog_clear,
  input wire irq_service
);
  // operands of the op taken at the previous edge
  logic [7:0] m_q;
  logic [7:0] a_q;
  logic [5:0] s_q;
  wire t = op_valid && op_ready && !halted;
  always @(posedge clock) m_q <= mem_rdata;
  always @(posedge clock) a_q <= acc;
  always @(posedge clock) s_q <= status;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  a_dec_mem_write: assert property (t && op == `MIE_OP_DEC_M |=>
    mem_we && mem_wdata == m_q - 8'h01 && status == {s_q[5:3],
    mem_wdata == 8'h00, s_q[1:0]}) else $error("memory decrement wrong");
  a_inc_acc_form: assert property (t && op == `MIE_OP_INC_A |=>
    !mem_we && acc == m_q + 8'h01 && status[2] == (acc == 8'h00))
    else $error("accumulator increment wrong");
  a_jump_two_cycle: assert property (t && op == `MIE_OP_JMP |=>
    pc_load && pc_value == $past(branch_addr) && !op_ready && status == s_q
    ##1 op_ready) else $error("jump wrong");
  a_halt_flags: assert property (t && op == `MIE_OP_HALT |=>
    halted && watchdog_clear && status[5:4] == 2'b01) else $error("halt wrong");
  a_halt_holds: assert property (halted |=> halted && !op_ready
    && !mem_we && !pc_load && acc == a_q) else $error("halted core moved");
  a_store_no_flags: assert property (t && op == `MIE_OP_MOV_AM |=>
    mem_we && mem_wdata == a_q && $stable(status)) else $error("store wrong");
  a_leave_interrupt_handler_enable: assert property (t && op == `MIE_OP_LEAVE_INTERRUPT_HANDLER |=>
    stack_pop && master_irq_enable && pc_value == $past(stack_top)
    && irq_service == $past(irq_pending)) else $error("leave_interrupt_handler wrong");
  a_carry_rotate: assert property (t && op == `MIE_OP_RLC_A |=>
    acc == {m_q[6:0], s_q[0]} && status[0] == m_q[7])
    else $error("rotate through carry wrong");
  a_skip_on_zero: assert property (t && op == `MIE_OP_SDZ_A |=>
    acc == m_q - 8'h01 && skip_next == (acc == 8'h00) && status == s_q
    && op_ready == !skip_next) else $error("skip wrong");
  a_idle_quiet: assert property (t && op == `MIE_OP_IDLE |=>
    !mem_we && !pc_load && !skip_next && acc == a_q && status == s_q)
    else $error("idle changed state");
  c_skip: cover property (t && op == `MIE_OP_SDZ_M ##1 skip_next);
  c_irq: cover property (irq_service);
  c_halt: cover property (halted);
endmodule
bind mie_execute mie_execute_properties #(.PC_W(PC_W)) chk (.clock, .resetn,
  .op_valid, .op, .mem_rdata, .branch_addr, .stack_top, .irq_pending,
  .op_ready, .mem_we, .mem_wdata, .acc, .status, .master_irq_enable, .pc_load,
  .pc_value, .stack_pop, .skip_next, .halted, .watchdog_clear, .irq_service);
`default_nettype wire

// ### verification/mie_execute_tb.sv
// self-checking bench for the execute subset
`timescale 1ns/1ps
`default_nettype none
`include "mie_defs.vh"
module mie_execute_tb;
  localparam PC_W = 14;
  // op masks indexed by opcode: memory writers, accumulator writers, zero flag
  localparam logic [31:0] MEM_OPS = 32'h0655120A;
  localparam logic [31:0] ACC_OPS = 32'h09AA4D94;
  localparam logic [31:0] ZF_OPS = 32'h00001C1E;
  logic clock = 0, resetn = 0, op_valid = 0, irq_pending = 0;
  logic [4:0] op = 0;
  logic [7:0] operand = 0, mem_rdata = 0, ea = 0, ed = 0;
  logic [PC_W-1:0] branch_addr = 0, stack_top = 0;
  logic [5:0] es = 0;
  logic ew = 0, epl = 0, epop = 0, esk = 0, emie = 0, eirq = 0, eh = 0;
  logic [31:0] seed = 32'hDE1C20BE;
  int err_total = 0, checks = 0;
  wire op_ready, mem_we, master_irq_enable, pc_load, stack_pop, skip_next;
  wire halted, watchdog_clear, irq_service;
  wire [7:0] mem_wdata, acc;
  wire [5:0] status;
  wire [PC_W-1:0] pc_value;
  mie_execute #(.PC_W(PC_W)) DUT (.clock, .resetn, .op_valid, .op, .operand,
    .branch_addr, .mem_rdata, .stack_top, .irq_pending, .op_ready, .mem_we,
    .mem_wdata, .acc, .status, .master_irq_enable, .pc_load, .pc_value,
    .stack_pop, .skip_next, .halted, .watchdog_clear, .irq_service);
  initial forever #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic void model(input logic [4:0] o, input logic [7:0] m, x);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] v;
    logic c;
    c = es[0];
    v = 0;
    case (o)
      `MIE_OP_DEC_M, `MIE_OP_DEC_A, `MIE_OP_SDZ_M, `MIE_OP_SDZ_A: v = m - 8'h01;
      `MIE_OP_INC_M, `MIE_OP_INC_A: v = m + 8'h01;
      `MIE_OP_MOV_MA: v = m;
      `MIE_OP_MOV_XA, `MIE_OP_RET_X: v = x;
      `MIE_OP_MOV_AM: v = ea;
      `MIE_OP_OR_A, `MIE_OP_OR_M: v = ea | m;
      `MIE_OP_OR_X: v = ea | x;
      `MIE_OP_RL_M, `MIE_OP_RL_A: v = {m[6:0], m[7]};
      `MIE_OP_RLC_M, `MIE_OP_RLC_A: {es[0], v} = {m, c};
      `MIE_OP_RR_M, `MIE_OP_RR_A: v = {m[0], m[7:1]};
      `MIE_OP_RRC_M, `MIE_OP_RRC_A: {v, es[0]} = {c, m};
      `MIE_OP_SBC_A, `MIE_OP_SBC_M: begin
        d = {1'b0, ea} - {1'b0, m} - {8'h00, !c};
        h = {1'b0, ea[3:0]} - {1'b0, m[3:0]} - {4'h0, !c};
        v = d[7:0];
        es[3:0] = {ea[7] != m[7] && v[7] != ea[7], v == 8'h00, !h[4], !d[8]};
      end
      `MIE_OP_HALT: begin
        eh = 1;
        es[5:4] = 2'b01;
      end
      default: v = 0;
    endcase
    ew = MEM_OPS[o];
    ed = ew ? v : 8'h00;
    if (ACC_OPS[o]) ea = v;
    if (ZF_OPS[o]) es[2] = v == 8'h00;
    epop = o inside {`MIE_OP_RET, `MIE_OP_RET_X, `MIE_OP_LEAVE_INTERRUPT_HANDLER};
    epl = epop || o == `MIE_OP_JMP;
    esk = (o == `MIE_OP_SDZ_M || o == `MIE_OP_SDZ_A) && v == 8'h00;
    eirq = o == `MIE_OP_LEAVE_INTERRUPT_HANDLER && irq_pending;
    if (o == `MIE_OP_LEAVE_INTERRUPT_HANDLER) emie = 1;
  endfunction
  function automatic logic [28:0] got();
    return {acc, status, mem_we, mem_we ? mem_wdata : 8'h00, pc_load,
      stack_pop, skip_next, master_irq_enable, irq_service, halted};
  endfunction
  task automatic cmp(input logic [28:0] g, e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // two-cycle ops leave op_valid up; the dummy cycle must ignore it
  task automatic issue(input logic [4:0] o);
    logic [31:0] r;
    int n;
    r = rnd();
    n = 0;
    while (op_ready !== 1'b1 && n < 9) begin
      @(posedge clock);
      #1 n++;
    end
    op_valid = 1;
    op = o;
    irq_pending = r[31];
    operand = r[23:16];
    mem_rdata = r[3:0] == 1 ? 8'h01 : r[3:0] == 2 ? 8'hFF : r[15:8];
    branch_addr = r[29:16];
    stack_top = r[27:14];
    model(o, mem_rdata, operand);
    @(posedge clock);
    #1 cmp(got(), {ea, es, ew, ed, epl, epop, esk, emie, eirq, eh});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] pick;
    repeat (8) @(posedge clock);
    #1 cmp(got(), 29'h0);
    resetn = 1;
    for (int i = 0; i < 28; i++) if (i != 5) issue(i[4:0]);
    $display("test directed ops done");
    // a pick of 5 is issued as idle, so halt can never slip into the random run
    for (int i = 0; i < 400; i++) begin
      pick = rnd() % 28;
      issue(pick == 5 ? 5'h00 : pick[4:0]);
    end
    $display("test random ops done");
    issue(`MIE_OP_HALT);
    model(`MIE_OP_IDLE, 8'h00, 8'h00);
    @(posedge clock);
    #1 op = `MIE_OP_INC_A;
    repeat (3) @(posedge clock);
    #1 cmp(got(), {ea, es, ew, ed, epl, epop, esk, emie, eirq, eh});
    $display("test halt done");
    complete_run();
  end
  initial begin
    #50000;
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
